// ---- hw/sbt_pkg.sv ----
package sbt_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and register map
  // ----------------------------------------------------------------
  localparam int WB_AW = 5;
  localparam int WB_DW = 32;
  localparam logic [WB_AW-1:0] OFS_CTRL1 = 5'h00;
  localparam logic [WB_AW-1:0] OFS_CTRL2 = 5'h04;
  localparam logic [WB_AW-1:0] OFS_BAUD = 5'h08;
  localparam logic [WB_AW-1:0] OFS_STATUS = 5'h0C;
  localparam logic [WB_AW-1:0] OFS_DATA = 5'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STAT_RX_FULL_BIT = 7;
  localparam int STAT_TX_EMPTY_BIT = 5;
  localparam int STAT_FAULT_BIT = 4;
  localparam int CTRL2_FAULT_EN_BIT = 4;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h03;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] EDGE_LAST = 4'hF;
  localparam logic [3:0] PIN_RST = 4'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rx_irq_enable;
    logic spi_enable;
    logic tx_irq_enable;
    logic master_select;
    logic cpol;
    logic clock_phase;
    logic select_output_enable;
    logic bit_order_low_first;
  } sbt_ctrl1_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } sbt_state_t;

endpackage

// ---- hw/sbt_sync.sv ----
`timescale 1ns/1ps
module sbt_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] ff1;
  logic [WIDTH-1:0] ff2;
  logic [WIDTH-1:0] ff3;

  // A bit only moves once the second and third stages agree.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ff1 <= RST_VAL;
      ff2 <= RST_VAL;
      ff3 <= RST_VAL;
      q <= RST_VAL;
    end else begin
      ff1 <= d;
      ff2 <= ff1;
      ff3 <= ff2;
      q <= (ff2 & ~(ff2 ^ ff3)) | (q & (ff2 ^ ff3));
    end
  end
endmodule

// ---- hw/sbt_core.sv ----
`timescale 1ns/1ps
// Operation
// - Transfer completion sets receive-full, status bit 7.
// - Receive-full clears by status read, data read.
// - Transmit-empty, status bit 5, shows buffer room.
// - Transmit-empty clears by status read, data write.
// - Data write ignored without prior empty-flag status read.
// - Transmit-empty with its enable requests interrupt.
// - Buffer-to-shifter move sets transmit-empty again.
// - Idle write reaches shifter within two cycles.
// - Waiting byte loads and starts at transfer end.
// - No waiting byte: flag stays set, no move.
// - Mode fault bit 4 sets only when configured.
// - Mode fault clears by read, then control write.
// - Unused status bits zero; status writes ignored.
// - Data reads receive buffer, writes transmit buffer.
// - Sample one edge, change next; eight cycles.
// - Transfer end copies shifter into receive buffer.
// - Most significant first unless low-first bit set.
// - Unread receive buffer keeps old byte silently.
// - Fault drops master mode and clock, MOSI, select drivers; MISO then drives while selected.
// - Receive enable gates receive-full and fault interrupts.
module sbt_core (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [sbt_pkg::WB_AW-1:0] WB_ADR_I,
  input wire logic [sbt_pkg::WB_DW-1:0] WB_DAT_I,
  output logic [sbt_pkg::WB_DW-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic IRQ,
  input wire logic SERIAL_CLOCK_PIN_I,
  output logic SERIAL_CLOCK_PIN_O,
  output logic SERIAL_CLOCK_PIN_OE,
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE,
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE,
  input wire logic SEL_N_I,
  output logic SEL_N_O,
  output logic SEL_N_OE
);
  import sbt_pkg::*;

  sbt_ctrl1_t ctrl1;
  logic fault_detect_enable;
  logic [7:0] baud;
  logic rx_full_flag;
  logic tx_empty_flag;
  logic mode_fault_flag;
  logic rx_arm;
  logic tx_arm;
  logic mf_arm;
  logic [7:0] rx_buf;
  logic [7:0] tx_buf;
  logic [7:0] shifter;
  logic [7:0] next_shifter;
  logic samp;
  logic out_bit;
  sbt_state_t state;
  logic [3:0] edge_cnt;
  logic [7:0] div_cnt;
  logic sck_lvl;
  logic sck_prev;
  logic sel_out;
  logic [3:0] pin_q;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic sel_n_s;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  sbt_sync #(.WIDTH(4), .RST_VAL(PIN_RST)) u_pin_sync (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .d({SERIAL_CLOCK_PIN_I, MOSI_I, MISO_I, SEL_N_I}),
    .q(pin_q)
  );
  assign sck_s = pin_q[3];
  assign mosi_s = pin_q[2];
  assign miso_s = pin_q[1];
  assign sel_n_s = pin_q[0];

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  logic req;
  logic acc;
  logic wr;
  logic rd;
  logic hit_ctrl1;
  logic hit_status;
  logic hit_data;
  logic [7:0] status_byte;
  logic [7:0] rd_byte;

  assign req = WB_CYC_I & WB_STB_I;
  assign acc = req & WB_ACK_O;
  assign wr = acc & WB_WE_I & WB_SEL_I[0];
  assign rd = acc & ~WB_WE_I;
  assign hit_ctrl1 = WB_ADR_I == OFS_CTRL1;
  assign hit_status = WB_ADR_I == OFS_STATUS;
  assign hit_data = WB_ADR_I == OFS_DATA;

  always_comb begin
    status_byte = 8'h00;
    status_byte[STAT_RX_FULL_BIT] = rx_full_flag;
    status_byte[STAT_TX_EMPTY_BIT] = tx_empty_flag;
    status_byte[STAT_FAULT_BIT] = mode_fault_flag;
  end

  always_comb begin
    unique case (WB_ADR_I)
      OFS_CTRL1: rd_byte = ctrl1;
      OFS_CTRL2: rd_byte = 8'(fault_detect_enable) << CTRL2_FAULT_EN_BIT;
      OFS_BAUD: rd_byte = baud;
      OFS_STATUS: rd_byte = status_byte;
      OFS_DATA: rd_byte = rx_buf;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= req & ~WB_ACK_O;
      if (req & ~WB_ACK_O) begin
        WB_DAT_O <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine decode
  // ----------------------------------------------------------------
  logic master_mode;
  logic selected;
  logic fault_cond;
  logic load;
  logic m_tick;
  logic s_edge;
  logic edge_ev;
  logic is_sample;
  logic din;
  logic done;
  logic shift_now;
  logic abort;
  logic [7:0] final_byte;

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                          input logic low_first);
    return low_first ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

  assign master_mode = ctrl1.spi_enable & ctrl1.master_select;
  assign selected = ctrl1.spi_enable & ~ctrl1.master_select & ~sel_n_s;
  assign fault_cond = master_mode & fault_detect_enable & ~ctrl1.select_output_enable
                      & ~sel_n_s;
  assign load = ~tx_empty_flag & (state == ST_IDLE) & ctrl1.spi_enable
                & ~fault_cond;
  assign m_tick = master_mode & (state == ST_RUN) & (div_cnt == baud);
  assign s_edge = selected & (sck_s != sck_prev);
  assign edge_ev = master_mode ? m_tick : s_edge;
  assign is_sample = edge_cnt[0] == ctrl1.clock_phase;
  assign din = master_mode ? miso_s : mosi_s;
  assign done = edge_ev & (edge_cnt == EDGE_LAST) & (state == ST_RUN);
  assign shift_now = edge_ev & ~is_sample & (edge_cnt != EDGE_LAST)
                     & ~(ctrl1.clock_phase & (edge_cnt == 4'h0));
  assign abort = fault_cond | ~ctrl1.spi_enable | (~master_mode & sel_n_s);
  assign final_byte = shift_in(shifter, ctrl1.clock_phase ? din : samp,
                               ctrl1.bit_order_low_first);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl1 <= CTRL1_RST;
      fault_detect_enable <= 1'b0;
      baud <= BAUD_RST;
    end else begin
      if (wr & hit_ctrl1) begin
        ctrl1 <= WB_DAT_I[7:0];
      end
      if (wr & (WB_ADR_I == OFS_CTRL2)) begin
        fault_detect_enable <= WB_DAT_I[CTRL2_FAULT_EN_BIT];
      end
      if (wr & (WB_ADR_I == OFS_BAUD)) begin
        baud <= WB_DAT_I[7:0];
      end
      if (fault_cond) begin
        ctrl1.master_select <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  logic tx_wr;
  logic rx_clr;
  logic rx_take;
  logic mf_clr;

  assign tx_wr = wr & hit_data & tx_arm;
  assign rx_clr = rd & hit_data & rx_arm;
  assign rx_take = done & (~rx_full_flag | rx_clr);
  assign mf_clr = wr & hit_ctrl1 & mf_arm;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_empty_flag <= 1'b1;
      tx_arm <= 1'b0;
      tx_buf <= DATA_RST;
    end else begin
      if (rd & hit_status & tx_empty_flag) begin
        tx_arm <= 1'b1;
      end else if (tx_wr) begin
        tx_arm <= 1'b0;
      end
      if (tx_wr) begin
        tx_buf <= WB_DAT_I[7:0];
        tx_empty_flag <= 1'b0;
      end
      if (load) begin
        tx_empty_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_full_flag <= 1'b0;
      rx_arm <= 1'b0;
      rx_buf <= DATA_RST;
    end else begin
      if (rx_clr) begin
        rx_full_flag <= 1'b0;
        rx_arm <= 1'b0;
      end else if (rd & hit_status & rx_full_flag) begin
        rx_arm <= 1'b1;
      end
      if (rx_take) begin
        rx_full_flag <= 1'b1;
        rx_buf <= final_byte;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_fault_flag <= 1'b0;
      mf_arm <= 1'b0;
    end else begin
      if (mf_clr) begin
        mode_fault_flag <= 1'b0;
        mf_arm <= 1'b0;
      end else if (rd & hit_status & mode_fault_flag) begin
        mf_arm <= 1'b1;
      end
      if (fault_cond) begin
        mode_fault_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= (tx_empty_flag & ctrl1.tx_irq_enable)
             | ((rx_full_flag | mode_fault_flag) & ctrl1.rx_irq_enable);
    end
  end

  // ----------------------------------------------------------------
  // Shifter and bit timing
  // ----------------------------------------------------------------
  always_comb begin
    next_shifter = shifter;
    if (load) begin
      next_shifter = tx_buf;
    end else if (done) begin
      next_shifter = final_byte;
    end else if (shift_now) begin
      next_shifter = shift_in(shifter, samp, ctrl1.bit_order_low_first);
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      shifter <= DATA_RST;
      out_bit <= 1'b0;
      samp <= 1'b0;
    end else begin
      shifter <= next_shifter;
      out_bit <= ctrl1.bit_order_low_first ? next_shifter[0] : next_shifter[7];
      if (edge_ev & is_sample) begin
        samp <= din;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if ((master_mode & load) | (s_edge & ~abort)) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (done | abort) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      edge_cnt <= 4'h0;
      div_cnt <= 8'h00;
      sck_lvl <= 1'b0;
      sck_prev <= 1'b0;
      sel_out <= 1'b1;
    end else begin
      sck_prev <= sck_s;
      if (abort | (master_mode & (state == ST_IDLE))) begin
        edge_cnt <= 4'h0;
      end else if (edge_ev) begin
        edge_cnt <= edge_cnt + 4'h1;
      end
      if ((state == ST_IDLE) | m_tick) begin
        div_cnt <= 8'h00;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
      if (~master_mode | (state == ST_IDLE)) begin
        sck_lvl <= ctrl1.cpol;
      end else if (m_tick) begin
        sck_lvl <= ~sck_lvl;
      end
      sel_out <= ~(load | ((state == ST_RUN) & ~done & ~abort));
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  assign SERIAL_CLOCK_PIN_O = sck_lvl;
  assign SERIAL_CLOCK_PIN_OE = master_mode;
  assign MOSI_O = out_bit;
  assign MOSI_OE = master_mode;
  assign MISO_O = out_bit;
  assign MISO_OE = selected;
  assign SEL_N_O = sel_out;
  assign SEL_N_OE = master_mode & fault_detect_enable & ctrl1.select_output_enable;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);

  rx_set_a: assert property (done && !rx_full_flag |=> rx_full_flag)
    else $error("receive-full not set after transfer");
  rx_hold_a: assert property (rx_full_flag && !rx_arm |=> rx_full_flag)
    else $error("receive-full cleared without status read");
  tx_room_a: assert property (wr && hit_data && tx_arm |=> !tx_empty_flag
                              && tx_buf == $past(WB_DAT_I[7:0]))
    else $error("accepted data write not queued");
  wr_drop_a: assert property (wr && hit_data && !tx_arm |=> $stable(tx_buf))
    else $error("data write taken without status read");
  tx_irq_a: assert property (tx_empty_flag && ctrl1.tx_irq_enable |=> IRQ)
    else $error("transmit interrupt missing");
  idle_load_a: assert property (tx_wr && master_mode && state == ST_IDLE
                                |-> ##[1:2] tx_empty_flag)
    else $error("idle write did not reach shifter in two cycles");
  no_move_a: assert property (tx_empty_flag && !tx_wr |=> $stable(tx_buf)
                              && tx_empty_flag)
    else $error("empty buffer changed without a write");
  fault_gate_a: assert property ($rose(mode_fault_flag) |-> $past(ctrl1.master_select)
                                 && $past(fault_detect_enable)
                                 && !$past(ctrl1.select_output_enable))
    else $error("mode fault set outside master fault mode");
  fault_drop_a: assert property ($rose(mode_fault_flag) |-> !ctrl1.master_select
                                 && !SERIAL_CLOCK_PIN_OE && !MOSI_OE)
    else $error("mode fault left master drivers on");
  overrun_a: assert property (done && rx_full_flag && !rx_clr |=> $stable(rx_buf))
    else $error("overrun replaced receive buffer");
  stat_zero_a: assert property (req && !WB_ACK_O && !WB_WE_I && hit_status
                                |=> WB_DAT_O[3:0] == 4'h0 && !WB_DAT_O[6])
    else $error("unused status bits read nonzero");

  xfer_c: cover property (done && !rx_full_flag);
  b2b_c: cover property (done ##1 load);
  fault_c: cover property ($rose(mode_fault_flag));
  overrun_c: cover property (done && rx_full_flag);
endmodule

// ---- dv/sbt_slave_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Serial slave on the far side, clock mode 0, most significant first
// ----------------------------------------------------------------
module sbt_slave_model (
  input wire logic sck,
  input wire logic sel_n,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] rx_byte,
  output int frames
);
  logic [7:0] sh_tx;
  logic [7:0] sh_rx;
  int bits;

  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    frames = 0;
    bits = 0;
  end

  // The byte to send changes with each frame so that a stale byte shows up.
  always @(negedge sel_n) begin
    sh_tx = 8'h96 + frames[7:0];
    bits = 0;
    miso = sh_tx[7];
  end

  always @(posedge sck) begin
    if (!sel_n && bits < 8) begin
      sh_rx = {sh_rx[6:0], mosi};
      bits++;
      if (bits == 8) begin
        rx_byte = sh_rx;
        frames++;
      end
    end
  end

  always @(negedge sck) begin
    if (!sel_n && bits < 8) begin
      sh_tx = {sh_tx[6:0], 1'b0};
      miso = sh_tx[7];
    end
  end

  // A released data line shows no stale level.
  always @(posedge sel_n) begin
    miso = ~miso;
  end
endmodule

// ---- dv/sbt_core_test.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("Error %0t: got %0h expected %0h", $time, got, exp); end end
module spi_buffered_transfer_core_test;
  import sbt_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'hF;
  logic [WB_AW-1:0] adr = '0;
  logic [WB_DW-1:0] dat_i = '0;
  logic tb_sel_n = 1'b1;
  logic tb_sck = 1'b0;
  logic tb_mosi = 1'b1;
  logic [7:0] m_rx;
  logic [WB_DW-1:0] dat_o, rd;
  logic ack, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, sel_o, sel_oe;
  logic pm_miso;
  logic [7:0] pm_rx;
  int pm_frames;
  int n_errors = 0;
  int check_count = 0;
  wire logic sck_w = sck_oe ? sck_o : tb_sck;
  wire logic mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire logic miso_w = miso_oe ? miso_o : pm_miso;
  wire logic sel_w = sel_oe ? sel_o : tb_sel_n;

  always #5 core_clk = ~core_clk;

  sbt_core dut_u (.CORE_CLK(core_clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .IRQ(irq), .SERIAL_CLOCK_PIN_I(sck_w), .SERIAL_CLOCK_PIN_O(sck_o),
    .SERIAL_CLOCK_PIN_OE(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe),
    .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE(miso_oe), .SEL_N_I(sel_w),
    .SEL_N_O(sel_o), .SEL_N_OE(sel_oe));

  sbt_slave_model slave_u (.sck(sck_w), .sel_n(sel_w), .mosi(mosi_w), .miso(pm_miso),
    .rx_byte(pm_rx), .frames(pm_frames));

  // ----------------------------------------------------------------
  // Bus cycles and waits
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [WB_AW-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= {24'h000000, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 100) begin
      n_errors++;
      $display("Error %0t: bus timeout", $time);
    end
    @(posedge core_clk);
  endtask

  task automatic rdchk(input logic [WB_AW-1:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    `CHK(rd, {24'h000000, e})
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (pm_frames < n && k < 2000) begin
      @(posedge core_clk);
      k++;
    end
    idle(30);
    `CHK(pm_frames, n)
  endtask

  // Plays the far-side master for slave-mode runs: clock mode 0, most significant first.
  task automatic ext_xfer(input logic [7:0] tx, output logic [7:0] got);
    got = 8'h00;
    tb_sel_n <= 1'b0;
    tb_mosi <= tx[7];
    #62.5;
    for (int i = 7; i >= 0; i--) begin
      tb_sck <= 1'b1;
      got = {got[6:0], miso_w};
      #62.5;
      tb_sck <= 1'b0;
      if (i > 0) begin
        tb_mosi <= tx[i-1];
      end
      #62.5;
    end
    tb_sel_n <= 1'b1;
    @(posedge core_clk);
  endtask

  task automatic results();
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rdchk(OFS_DATA, 8'h00);
    rdchk(5'h14, 8'h00);
    wb(1'b1, OFS_CTRL2, 8'h10);
    // The three-stage pin inputs need a half period longer than four cycles.
    wb(1'b1, OFS_BAUD, 8'h05);
    wb(1'b1, OFS_CTRL1, 8'h52);
    wb(1'b1, OFS_DATA, 8'h11);
    idle(100);
    `CHK(pm_frames, 0)
    wb(1'b1, OFS_STATUS, 8'hFF);
    rdchk(OFS_STATUS, 8'h20);
    wb(1'b1, OFS_DATA, 8'hA5);
    rdchk(OFS_STATUS, 8'h20);
    wb(1'b1, OFS_DATA, 8'h3C);
    rdchk(OFS_STATUS, 8'h00);
    wait_frames(1);
    `CHK(pm_rx, 8'hA5)
    wait_frames(2);
    `CHK(pm_rx, 8'h3C)
    rdchk(OFS_STATUS, 8'hA0);
    rdchk(OFS_DATA, 8'h96);
    rdchk(OFS_STATUS, 8'h20);
    wb(1'b1, OFS_CTRL1, 8'h53);
    rdchk(OFS_STATUS, 8'h20);
    wb(1'b1, OFS_DATA, 8'h01);
    wait_frames(3);
    `CHK(pm_rx, 8'h80)
    rdchk(OFS_STATUS, 8'hA0);
    wb(1'b1, OFS_CTRL1, 8'hD3);
    idle(3);
    `CHK(irq, 1'b1)
    wb(1'b1, OFS_CTRL1, 8'h53);
    idle(3);
    `CHK(irq, 1'b0)
    wb(1'b1, OFS_CTRL1, 8'h73);
    idle(3);
    `CHK(irq, 1'b1)
    wb(1'b1, OFS_CTRL1, 8'h53);
    rdchk(OFS_STATUS, 8'hA0);
    rdchk(OFS_DATA, 8'h19);
    wb(1'b1, OFS_CTRL1, 8'h51);
    tb_sel_n <= 1'b0;
    idle(10);
    rdchk(OFS_STATUS, 8'h30);
    `CHK(sck_oe, 1'b0)
    `CHK(mosi_oe, 1'b0)
    rdchk(OFS_CTRL1, 8'h41);
    tb_sel_n <= 1'b1;
    idle(10);
    wb(1'b1, OFS_CTRL1, 8'h41);
    rdchk(OFS_STATUS, 8'h20);
    wb(1'b1, OFS_CTRL1, 8'h40);
    rdchk(OFS_STATUS, 8'h20);
    wb(1'b1, OFS_DATA, 8'h6B);
    idle(4);
    ext_xfer(8'hC4, m_rx);
    idle(10);
    `CHK(m_rx, 8'h6B)
    rdchk(OFS_STATUS, 8'hA0);
    rdchk(OFS_DATA, 8'hC4);
    results();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    results();
  end
endmodule
